/* ifc_pkg.sv */
// Constants for the interrupt enable and flag control block.
// Assumes a single 25 MHz core clock domain and an AXI4-Lite master.
package ifc_pkg;
    // Clock period in ns
    localparam int unsigned CLK_PERIOD_NS = 40;
    // Bus geometry
    localparam int unsigned ADDR_W = 12;
    localparam int unsigned DATA_W = 32;
    // Register indices, byte address is four times the index
    localparam int unsigned CTRL_IDX_LO = 'h0B;
    localparam int unsigned CTRL_IDX_HI = 'h8B;
    localparam int unsigned STAT_IDX = 'h10;
    localparam int unsigned CLR_IDX = 'h11;
    localparam int unsigned IEN_IDX = 'h12;
    localparam logic [ADDR_W-1:0] CTRL_ADDR_LO = ADDR_W'(CTRL_IDX_LO * 4);
    localparam logic [ADDR_W-1:0] CTRL_ADDR_HI = ADDR_W'(CTRL_IDX_HI * 4);
    localparam logic [ADDR_W-1:0] STAT_ADDR = ADDR_W'(STAT_IDX * 4);
    localparam logic [ADDR_W-1:0] CLR_ADDR = ADDR_W'(CLR_IDX * 4);
    localparam logic [ADDR_W-1:0] IEN_ADDR = ADDR_W'(IEN_IDX * 4);
    // Control register fields
    localparam int unsigned GLOBAL_EN_BIT = 7;
    localparam int unsigned PERIPH_EN_BIT = 6;
    localparam int unsigned TOVIE_BIT = 5;
    localparam int unsigned EXTIE_BIT = 4;
    localparam int unsigned PCIE_BIT = 3;
    localparam int unsigned TOVF_BIT = 2;
    localparam int unsigned EXTF_BIT = 1;
    localparam int unsigned PCF_BIT = 0;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    // Event status layout: one bit per flag, same positions as flags
    localparam int unsigned EVT_W = 3;
    localparam logic [EVT_W-1:0] EVT_RESET = 3'h0;
    // Responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // Return from interrupt length in core cycles
    localparam int unsigned RET_CYCLES = 2;
    // Return sequencer states, Gray from RET_IDLE to RET_SECOND; two bits change on the step back to RET_IDLE
    typedef enum logic [1:0] {
        RET_IDLE = 2'h0,
        RET_FIRST = 2'h1,
        RET_SECOND = 2'h3
    } ifc_ret_state_type;
endpackage : ifc_pkg

/* ifc_edge.sv */
// Level change and rising edge detector, one lane per input bit.
// Assumes inputs already synchronous to the clock.
`timescale 1ns/10ps
`default_nettype none
module ifc_edge #(
    parameter int unsigned W = 4
) (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic [W-1:0] lvl_i,
    output logic [W-1:0] chg_o,
    output logic [W-1:0] rise_o
);
    logic [W-1:0] prev;
    logic [W-1:0] next_prev;
    logic primed;
    logic next_primed;

    initial begin
        if (W < 1) begin
            $error("ifc_edge needs at least one lane");
        end
    end

    always_comb begin
        next_prev = lvl_i;
        next_primed = 1'b1;
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            prev <= '0;
            primed <= 1'b0;
        end else begin
            prev <= next_prev;
            primed <= next_primed;
        end
    end

    // Per lane compare against last sample
    for (genvar i = 0; i < W; i++) begin : g_lane
        assign chg_o[i] = primed & (lvl_i[i] ^ prev[i]);
        assign rise_o[i] = primed & lvl_i[i] & ~prev[i];
    end
endmodule : ifc_edge
`default_nettype wire

/* ifc_ret.sv */
// Return from interrupt sequencer: two cycles, then loads the PC.
// Assumes the core gives a one-cycle request and a stable stack top.
`timescale 1ns/10ps
`default_nettype none
module ifc_ret
    import ifc_pkg::*;
#(
    parameter int unsigned PC_W = 11
) (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic ret_i,
    input wire logic [PC_W-1:0] tos_i,
    output logic load_o,
    output logic [PC_W-1:0] pc_o
);
    ifc_ret_state_type state;
    ifc_ret_state_type next_state;
    logic [PC_W-1:0] next_pc;
    logic next_load;

    initial begin
        if (PC_W < 1 || RET_CYCLES != 2) begin
            $error("ifc_ret cannot serve these settings");
        end
    end

    always_comb begin
        next_state = state;
        next_pc = pc_o;
        next_load = 1'b0;
        case (state)
            RET_IDLE: begin
                if (ret_i) begin
                    next_state = RET_FIRST;
                    next_pc = tos_i;
                end
            end
            RET_FIRST: begin
                next_state = RET_SECOND;
                next_load = 1'b1;
            end
            RET_SECOND: begin
                next_state = RET_IDLE;
            end
            default: begin
                next_state = RET_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state <= RET_IDLE;
            pc_o <= '0;
            load_o <= 1'b0;
        end else begin
            state <= next_state;
            pc_o <= next_pc;
            load_o <= next_load;
        end
    end

    a_ret_two_cycles: assert property (
        @(posedge clk_i) disable iff (!rstn_i)
        (ret_i && state == RET_IDLE) |=> !load_o ##1 load_o ##1 !load_o
    ) else $error("Return did not load on its second cycle");
endmodule : ifc_ret
`default_nettype wire

/* ifc_top.sv */
// Interrupt enable and flag control with an AXI4-Lite register slave.
// Assumes one clock, sources synchronous to it, one bus master.
//
// Register access over AXI4-Lite was decided locally.
`timescale 1ns/10ps
`default_nettype none
module ifc_top
    import ifc_pkg::*;
#(
    parameter int unsigned PC_W = 11,
    parameter bit EXT_RISE = 1'b1
) (
    input wire logic CLK_I,
    input wire logic RSTN_I,
    input wire logic [ADDR_W-1:0] S_AXI_AWADDR_I,
    input wire logic S_AXI_AWVALID_I,
    output logic S_AXI_AWREADY_O,
    input wire logic [DATA_W-1:0] S_AXI_WDATA_I,
    input wire logic [DATA_W/8-1:0] S_AXI_WSTRB_I,
    input wire logic S_AXI_WVALID_I,
    output logic S_AXI_WREADY_O,
    output logic [1:0] S_AXI_BRESP_O,
    output logic S_AXI_BVALID_O,
    input wire logic S_AXI_BREADY_I,
    input wire logic [ADDR_W-1:0] S_AXI_ARADDR_I,
    input wire logic S_AXI_ARVALID_I,
    output logic S_AXI_ARREADY_O,
    output logic [DATA_W-1:0] S_AXI_RDATA_O,
    output logic [1:0] S_AXI_RRESP_O,
    output logic S_AXI_RVALID_O,
    input wire logic S_AXI_RREADY_I,
    input wire logic TIMER_OVF_I,
    input wire logic EXT_IRQ_PIN_I,
    input wire logic [2:0] PORT_PIN_I,
    input wire logic PERIPH_IRQ_I,
    input wire logic RETURN_FROM_IRQ_I,
    input wire logic [PC_W-1:0] TOS_I,
    output logic PC_LOAD_O,
    output logic [PC_W-1:0] PC_O,
    output logic CORE_IRQ_O,
    output logic IRQ_O
);
    logic [7:0] ctrl;
    logic [7:0] next_ctrl;
    logic [EVT_W-1:0] ist;
    logic [EVT_W-1:0] next_ist;
    logic [EVT_W-1:0] ien;
    logic [EVT_W-1:0] next_ien;
    logic next_core_irq;
    logic next_irq;
    logic aw_full;
    logic next_aw_full;
    logic w_full;
    logic next_w_full;
    logic [ADDR_W-1:0] awaddr;
    logic [ADDR_W-1:0] next_awaddr;
    logic [DATA_W-1:0] wdata;
    logic [DATA_W-1:0] next_wdata;
    logic wstrb0;
    logic next_wstrb0;
    logic next_awready;
    logic next_wready;
    logic next_bvalid;
    logic [1:0] next_bresp;
    logic next_arready;
    logic next_rvalid;
    logic [DATA_W-1:0] next_rdata;
    logic [1:0] next_rresp;
    logic aw_hs;
    logic w_hs;
    logic ar_hs;
    logic do_write;
    logic wr_ctrl;
    logic [3:0] chg;
    logic [3:0] rise;
    logic [EVT_W-1:0] evt;
    logic ret_load;

    initial begin
        if (PC_W < 1 || PC_W > DATA_W) begin
            $error("ifc_top program counter width out of range");
        end
    end

    // Lanes 0 to 2: port pins, lane 3: external interrupt pin
    ifc_edge #(
        .W(4)
    ) u_edge (
        .clk_i(CLK_I),
        .rstn_i(RSTN_I),
        .lvl_i({EXT_IRQ_PIN_I, PORT_PIN_I}),
        .chg_o(chg),
        .rise_o(rise)
    );

    ifc_ret #(
        .PC_W(PC_W)
    ) u_ret (
        .clk_i(CLK_I),
        .rstn_i(RSTN_I),
        .ret_i(RETURN_FROM_IRQ_I),
        .tos_i(TOS_I),
        .load_o(ret_load),
        .pc_o(PC_O)
    );

    // Source events, flag positions
    always_comb begin
        evt = '0;
        evt[TOVF_BIT] = TIMER_OVF_I;
        evt[EXTF_BIT] = EXT_RISE ? rise[3] : (chg[3] & ~rise[3]);
        evt[PCF_BIT] = |chg[2:0];
    end

    assign aw_hs = S_AXI_AWVALID_I & S_AXI_AWREADY_O;
    assign w_hs = S_AXI_WVALID_I & S_AXI_WREADY_O;
    assign ar_hs = S_AXI_ARVALID_I & S_AXI_ARREADY_O;
    assign do_write = aw_full & w_full & ~S_AXI_BVALID_O;
    assign wr_ctrl = do_write & wstrb0 &
        (awaddr == CTRL_ADDR_LO || awaddr == CTRL_ADDR_HI);

    // Write channel
    always_comb begin
        next_awaddr = aw_hs ? S_AXI_AWADDR_I : awaddr;
        next_wdata = w_hs ? S_AXI_WDATA_I : wdata;
        next_wstrb0 = w_hs ? S_AXI_WSTRB_I[0] : wstrb0;
        next_aw_full = (aw_full & ~do_write) | aw_hs;
        next_w_full = (w_full & ~do_write) | w_hs;
        next_bvalid = do_write | (S_AXI_BVALID_O & ~S_AXI_BREADY_I);
        next_bresp = S_AXI_BRESP_O;
        if (do_write) begin
            case (awaddr)
                CTRL_ADDR_LO, CTRL_ADDR_HI, STAT_ADDR, CLR_ADDR,
                IEN_ADDR: begin
                    next_bresp = RESP_OKAY;
                end
                default: begin
                    next_bresp = RESP_SLVERR;
                end
            endcase
        end
        next_awready = ~next_aw_full & ~next_bvalid;
        next_wready = ~next_w_full & ~next_bvalid;
    end

    // Register state
    always_comb begin
        next_ctrl = ctrl;
        next_ist = ist;
        next_ien = ien;
        if (wr_ctrl) begin
            next_ctrl = wdata[7:0];
        end
        if (ret_load) begin
            next_ctrl[GLOBAL_EN_BIT] = 1'b1;
        end
        // Set wins over a software clear
        next_ctrl[EVT_W-1:0] = next_ctrl[EVT_W-1:0] | evt;
        if (do_write && wstrb0 && awaddr == CLR_ADDR) begin
            next_ist = ist & ~wdata[EVT_W-1:0];
        end
        if (do_write && wstrb0 && awaddr == IEN_ADDR) begin
            next_ien = wdata[EVT_W-1:0];
        end
        next_ist = next_ist | evt;
        next_irq = |(next_ist & next_ien);
        next_core_irq = next_ctrl[GLOBAL_EN_BIT] & (
            (next_ctrl[TOVIE_BIT] & next_ctrl[TOVF_BIT]) |
            (next_ctrl[EXTIE_BIT] & next_ctrl[EXTF_BIT]) |
            (next_ctrl[PCIE_BIT] & next_ctrl[PCF_BIT]) |
            (next_ctrl[PERIPH_EN_BIT] & PERIPH_IRQ_I));
    end

    // Read channel
    always_comb begin
        next_rvalid = ar_hs | (S_AXI_RVALID_O & ~S_AXI_RREADY_I);
        next_rdata = S_AXI_RDATA_O;
        next_rresp = S_AXI_RRESP_O;
        if (ar_hs) begin
            next_rdata = '0;
            next_rresp = RESP_OKAY;
            case (S_AXI_ARADDR_I)
                CTRL_ADDR_LO, CTRL_ADDR_HI: begin
                    next_rdata[7:0] = ctrl;
                end
                STAT_ADDR: begin
                    next_rdata[EVT_W-1:0] = ist;
                end
                IEN_ADDR: begin
                    next_rdata[EVT_W-1:0] = ien;
                end
                CLR_ADDR: begin
                    next_rdata = '0;
                end
                default: begin
                    next_rresp = RESP_SLVERR;
                end
            endcase
        end
        next_arready = ~next_rvalid;
    end

    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            ctrl <= CTRL_RESET;
            ist <= EVT_RESET;
            ien <= EVT_RESET;
            CORE_IRQ_O <= 1'b0;
            IRQ_O <= 1'b0;
            aw_full <= 1'b0;
            w_full <= 1'b0;
            awaddr <= '0;
            wdata <= '0;
            wstrb0 <= 1'b0;
            S_AXI_AWREADY_O <= 1'b0;
            S_AXI_WREADY_O <= 1'b0;
            S_AXI_BVALID_O <= 1'b0;
            S_AXI_BRESP_O <= RESP_OKAY;
            S_AXI_ARREADY_O <= 1'b0;
            S_AXI_RVALID_O <= 1'b0;
            S_AXI_RDATA_O <= '0;
            S_AXI_RRESP_O <= RESP_OKAY;
            PC_LOAD_O <= 1'b0;
        end else begin
            ctrl <= next_ctrl;
            ist <= next_ist;
            ien <= next_ien;
            CORE_IRQ_O <= next_core_irq;
            IRQ_O <= next_irq;
            aw_full <= next_aw_full;
            w_full <= next_w_full;
            awaddr <= next_awaddr;
            wdata <= next_wdata;
            wstrb0 <= next_wstrb0;
            S_AXI_AWREADY_O <= next_awready;
            S_AXI_WREADY_O <= next_wready;
            S_AXI_BVALID_O <= next_bvalid;
            S_AXI_BRESP_O <= next_bresp;
            S_AXI_ARREADY_O <= next_arready;
            S_AXI_RVALID_O <= next_rvalid;
            S_AXI_RDATA_O <= next_rdata;
            S_AXI_RRESP_O <= next_rresp;
            PC_LOAD_O <= ret_load;
        end
    end

    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!RSTN_I);

    a_timer_flag_set: assert property (
        TIMER_OVF_I |=> ctrl[TOVF_BIT]
    ) else $error("Timer flag missed its event");
    a_ext_flag_set: assert property (
        evt[EXTF_BIT] |=> ctrl[EXTF_BIT]
    ) else $error("External flag missed its event");
    a_pin_flag_set: assert property (
        (PORT_PIN_I != $past(PORT_PIN_I)) && $past(RSTN_I, 2)
        |=> ctrl[PCF_BIT]
    ) else $error("Pin change flag missed a change");
    a_flag_holds: assert property (
        ctrl[TOVF_BIT] && !wr_ctrl |=> ctrl[TOVF_BIT]
    ) else $error("Timer flag dropped without a write");
    a_global_blocks: assert property (
        CORE_IRQ_O |-> ctrl[GLOBAL_EN_BIT]
    ) else $error("Core request with global enable low");
    a_timer_request: assert property (
        ctrl[GLOBAL_EN_BIT] && ctrl[TOVIE_BIT] && ctrl[TOVF_BIT]
        |-> CORE_IRQ_O
    ) else $error("Enabled timer flag gave no request");
    a_mask_request: assert property (
        CORE_IRQ_O |-> (ctrl[TOVIE_BIT] && ctrl[TOVF_BIT])
            || (ctrl[EXTIE_BIT] && ctrl[EXTF_BIT])
            || (ctrl[PCIE_BIT] && ctrl[PCF_BIT])
            || (ctrl[PERIPH_EN_BIT] && $past(PERIPH_IRQ_I))
    ) else $error("Request without an enabled source");
    a_ret_global_set: assert property (
        RETURN_FROM_IRQ_I && !ret_load ##1 1 |-> ##[1:2] ctrl[GLOBAL_EN_BIT]
    ) else $error("Return left global enable low");
    a_ctrl_write: assert property (
        wr_ctrl && !ret_load && evt == '0 |=> ctrl == $past(wdata[7:0])
    ) else $error("Control write not stored");
    a_bvalid_hold: assert property (
        S_AXI_BVALID_O && !S_AXI_BREADY_I |=> S_AXI_BVALID_O
    ) else $error("Write response dropped early");
endmodule : ifc_top
`default_nettype wire

/* ifc_core_model.sv */
// Core model: issues a return from interrupt with a stack top value.
// Assumes go_i is a one-cycle request from the bench.
`timescale 1ns/10ps
`default_nettype none
module ifc_core_model
    import ifc_pkg::*;
#(
    parameter int unsigned PC_W = 11
) (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic go_i,
    input wire logic [PC_W-1:0] tos_val_i,
    output logic ret_o,
    output logic [PC_W-1:0] tos_o
);
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ret_o <= 1'b0;
            tos_o <= '0;
        end else begin
            ret_o <= go_i;
            if (go_i) begin
                tos_o <= tos_val_i;
            end else if (ret_o) begin
                // Stack top not held after the pulse
                tos_o <= ~tos_o;
            end
        end
    end
endmodule : ifc_core_model
`default_nettype wire

/* tb_top.sv */
// Bench for the interrupt control block over AXI4-Lite.
// Assumes ifc_top and ifc_core_model; one 25 MHz clock.
`timescale 1ns/10ps
`default_nettype none
module tb_top
    import ifc_pkg::*;
;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic [ADDR_W-1:0] awaddr = '0;
    logic [ADDR_W-1:0] araddr = '0;
    logic [DATA_W-1:0] wdata = '0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0;
    logic tovf = 1'b0, ext = 1'b0, periph = 1'b0, go = 1'b0;
    logic [2:0] pins = 3'h0;
    logic [10:0] tosv = 11'h000;
    logic awready, wready, bvalid, arready, rvalid, ret, pc_load;
    logic core_irq, irq;
    logic [1:0] bresp, rresp, wresp_s, rresp_s;
    logic [DATA_W-1:0] rdata, rdat;
    logic [10:0] tos, pc;
    int mismatches = 0;
    int cmp_count = 0;
    localparam logic [8:0] TBL [12] = '{9'h024, 9'h0A4, 9'h084, 9'h0A0,
        9'h092, 9'h082, 9'h089, 9'h081, 9'h1C0, 9'h180, 9'h140, 9'h07F};

    always #(CLK_PERIOD_NS / 2) clk = ~clk;

    ifc_top #(.PC_W(11), .EXT_RISE(1'b1)) ifc_top_i (
        .CLK_I(clk), .RSTN_I(rstn),
        .S_AXI_AWADDR_I(awaddr), .S_AXI_AWVALID_I(awvalid),
        .S_AXI_AWREADY_O(awready), .S_AXI_WDATA_I(wdata),
        .S_AXI_WSTRB_I(4'hF), .S_AXI_WVALID_I(wvalid),
        .S_AXI_WREADY_O(wready), .S_AXI_BRESP_O(bresp),
        .S_AXI_BVALID_O(bvalid), .S_AXI_BREADY_I(bready),
        .S_AXI_ARADDR_I(araddr), .S_AXI_ARVALID_I(arvalid),
        .S_AXI_ARREADY_O(arready), .S_AXI_RDATA_O(rdata),
        .S_AXI_RRESP_O(rresp), .S_AXI_RVALID_O(rvalid),
        .S_AXI_RREADY_I(rready), .TIMER_OVF_I(tovf),
        .EXT_IRQ_PIN_I(ext), .PORT_PIN_I(pins), .PERIPH_IRQ_I(periph),
        .RETURN_FROM_IRQ_I(ret), .TOS_I(tos), .PC_LOAD_O(pc_load),
        .PC_O(pc), .CORE_IRQ_O(core_irq), .IRQ_O(irq)
    );

    ifc_core_model #(.PC_W(11)) ifc_core_model_i (
        .clk_i(clk), .rstn_i(rstn), .go_i(go), .tos_val_i(tosv),
        .ret_o(ret), .tos_o(tos)
    );

    task close_out;
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : close_out

    task chk(input string name, input logic [31:0] seen,
             input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    task guard(inout int n);
        n++;
        if (n > 100) begin
            mismatches++;
            close_out();
        end
    endtask : guard

    task wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
        logic ta, tw, da, dw;
        int n;
        @(posedge clk);
        awaddr <= a;
        awvalid <= 1'b1;
        wdata <= {24'h000000, d};
        wvalid <= 1'b1;
        da = 1'b0;
        dw = 1'b0;
        n = 0;
        while (!(da && dw)) begin
            @(negedge clk);
            ta = (awready === 1'b1);
            tw = (wready === 1'b1);
            @(posedge clk);
            if (ta && !da) begin
                da = 1'b1;
                awvalid <= 1'b0;
            end
            if (tw && !dw) begin
                dw = 1'b1;
                wvalid <= 1'b0;
            end
            guard(n);
        end
        bready <= 1'b1;
        ta = 1'b0;
        while (!ta) begin
            @(negedge clk);
            ta = (bvalid === 1'b1);
            wresp_s = bresp;
            @(posedge clk);
            guard(n);
        end
        bready <= 1'b0;
    endtask : wr

    task rd(input logic [ADDR_W-1:0] a);
        logic ta;
        int n;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        ta = 1'b0;
        n = 0;
        while (!ta) begin
            @(negedge clk);
            ta = (arready === 1'b1);
            @(posedge clk);
            guard(n);
        end
        arvalid <= 1'b0;
        rready <= 1'b1;
        ta = 1'b0;
        while (!ta) begin
            @(negedge clk);
            ta = (rvalid === 1'b1);
            rdat = rdata;
            rresp_s = rresp;
            @(posedge clk);
            guard(n);
        end
        rready <= 1'b0;
    endtask : rd

    function automatic logic exp_irq(input logic [8:0] e);
        return e[7] & ((e[5] & e[2]) | (e[4] & e[1]) | (e[3] & e[0])
            | (e[6] & e[8]));
    endfunction : exp_irq

    initial begin
        int k;
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        rd(CTRL_ADDR_LO);
        chk("ctrl reset", rdat, 32'h00000000);
        rd(STAT_ADDR);
        chk("status reset", rdat, 32'h00000000);
        rd(12'h100);
        chk("unmapped data", rdat, 32'h00000000);
        chk("unmapped rresp", 32'(rresp_s), 32'(RESP_SLVERR));
        wr(12'h104, 8'hFF);
        chk("unmapped bresp", 32'(wresp_s), 32'(RESP_SLVERR));
        wr(CTRL_ADDR_LO, 8'h5A);
        chk("bresp", 32'(wresp_s), 32'(RESP_OKAY));
        rd(CTRL_ADDR_HI);
        chk("ctrl mirror hi", rdat, 32'h0000005A);
        chk("ctrl rresp", 32'(rresp_s), 32'(RESP_OKAY));
        wr(CTRL_ADDR_HI, 8'hA5);
        rd(CTRL_ADDR_LO);
        chk("ctrl mirror lo", rdat, 32'h000000A5);
        for (int i = 0; i < 12; i++) begin
            periph <= TBL[i][8];
            wr(CTRL_ADDR_LO, TBL[i][7:0]);
            repeat (2) @(posedge clk);
            chk("core irq", 32'(core_irq), 32'(exp_irq(TBL[i])));
        end
        periph <= 1'b0;
        wr(CTRL_ADDR_LO, 8'h00);
        @(posedge clk);
        tovf <= 1'b1;
        ext <= 1'b1;
        pins <= 3'h4;
        @(posedge clk);
        tovf <= 1'b0;
        repeat (5) @(posedge clk);
        rd(CTRL_ADDR_LO);
        chk("flags held", rdat, 32'h00000007);
        chk("core irq masked", 32'(core_irq), 32'h0);
        rd(STAT_ADDR);
        chk("status set", rdat, 32'h00000007);
        chk("irq disabled", 32'(irq), 32'h0);
        wr(IEN_ADDR, 8'h02);
        repeat (2) @(posedge clk);
        chk("irq enabled", 32'(irq), 32'h1);
        wr(CLR_ADDR, 8'h07);
        rd(STAT_ADDR);
        chk("status clear", rdat, 32'h00000000);
        chk("irq cleared", 32'(irq), 32'h0);
        wr(CTRL_ADDR_LO, 8'h00);
        rd(CTRL_ADDR_LO);
        chk("flags cleared", rdat, 32'h00000000);
        @(posedge clk);
        ext <= 1'b0;
        repeat (3) @(posedge clk);
        rd(CTRL_ADDR_LO);
        chk("ext falling", rdat, 32'h00000000);
        for (int i = 0; i < 3; i++) begin
            @(posedge clk);
            pins[i] <= ~pins[i];
            repeat (3) @(posedge clk);
            rd(CTRL_ADDR_LO);
            chk("pin change", rdat, 32'h00000001);
            wr(CTRL_ADDR_LO, 8'h00);
        end
        @(posedge clk);
        go <= 1'b1;
        tosv <= 11'h5A5;
        @(posedge clk);
        go <= 1'b0;
        k = 1;
        while (pc_load !== 1'b1) begin
            @(negedge clk);
            if (pc_load !== 1'b1) begin
                @(posedge clk);
                k++;
                if (k > 100) begin
                    mismatches++;
                    close_out();
                end
            end
        end
        chk("return cycles", 32'(k), 32'(RET_CYCLES + 2));
        chk("return pc", 32'(pc), 32'h000005A5);
        rd(CTRL_ADDR_LO);
        chk("global enable set", rdat, 32'h00000080);
        @(posedge clk);
        rstn <= 1'b0;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        rd(CTRL_ADDR_HI);
        chk("ctrl second reset", rdat, 32'h00000000);
        close_out();
    end
endmodule : tb_top
`default_nettype wire
